/* File: hdl/ext_int_regs.svh */
// register offsets, field positions, reset values and timing counts
// assumes inclusion by the package only, whose macros the control block then uses
`ifndef EXT_INT_REGS_SVH
`define EXT_INT_REGS_SVH

// ---------------------------------------------------------------
// clock and timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS 8
`define LF_PERIOD_NS 30518
`define LF_DIV_CYC (`LF_PERIOD_NS / `CLK_PERIOD_NS)
`define LF_PRESCALE 4

// ---------------------------------------------------------------
// register indices (byte address four times the index) and byte addresses
// ---------------------------------------------------------------
`define IDX_POWER_GATE 14'hf77
`define IDX_CHAN1_CTRL 14'hfd8
`define IDX_CHAN2_CTRL 14'hfd9
`define ADDR_IRQ_STATUS 16'h0000
`define ADDR_IRQ_MASK 16'h0004
`define ADDR_MODE 16'h0008

// ---------------------------------------------------------------
// fields
// ---------------------------------------------------------------
`define PGATE_WIDTH 6
`define CTRL_SAMP_LSB 0
`define CTRL_EDGE_LSB 2
`define CTRL_LVL_BIT 4
`define MODE_SLOW_BIT 0

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RST_POWER_GATE 6'h00
`define RST_CHAN_CTRL 8'h00
`define RST_IRQ_MASK 2'h0

`endif

/* File: hdl/ext_int_pkg.sv */
// types shared by the external interrupt control block
// assumes ext_int_regs.svh is on the include path
`include "ext_int_regs.svh"

package ext_int_pkg;

    // ---------------------------------------------------------------
    // edge select codes
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        edge_rise = 2'h0,
        edge_fall = 2'h1,
        edge_both = 2'h2,
        edge_rsvd = 2'h3
    } edge_sel_t;

    // ---------------------------------------------------------------
    // whole state of the control block
    // ---------------------------------------------------------------
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [`PGATE_WIDTH-1:0] pgate;
        logic [1:0][1:0] edge_sel;
        logic [1:0][1:0] samp_sel;
        logic [1:0] lvl;
        logic [1:0] status;
        logic [1:0] mask;
        logic slow;
        logic [15:0] lf_cnt;
        logic [1:0] lf_q;
        logic [1:0][3:0] div_cnt;
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0][2:0] nc_shift;
        logic [1:0] filt;
        logic [1:0] req;
        logic irq;
    } state_t;

endpackage

/* File: hdl/ext_int_ctrl.sv */
// external interrupt input control: power gating, noise canceller,
// edge detection and interrupt latches for channels 1 and 2, on apb
// assumes external pins are asynchronous, one clock pclk at 125 mhz

module ext_int_ctrl
    import ext_int_pkg::*;
#(
    parameter logic [15:0] LF_DIV = 16'(`LF_DIV_CYC)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] ext_int_pin,
    input wire logic [1:0] int_accept,
    output logic [1:0] chan_req,
    output logic [1:0] chan_filtered,
    output logic irq
);

    // ---------------------------------------------------------------
    // state and next state
    // ---------------------------------------------------------------
    state_t r_ff;
    state_t nxt_r;

    logic lf_tick;
    logic lf4_tick;
    logic [1:0] tick;
    logic [1:0] edge_hit;
    logic acc_wr;
    logic acc_rd;
    logic [31:0] rd_word;
    logic rd_hit;
    logic [1:0] w1c;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] idx_addr(input logic [13:0] idx);
        return {16'h0000, idx, 2'b00};
    endfunction

    function automatic logic [3:0] samp_limit(input logic [1:0] sel);
        logic [3:0] lim;
        lim = 4'h0;
        unique case (sel)
            2'h0: lim = 4'h0;
            2'h1: lim = 4'h3;
            2'h2: lim = 4'h7;
            2'h3: lim = 4'hf;
        endcase
        return lim;
    endfunction

    function automatic logic edge_match(input logic [1:0] sel, input logic now_high);
        logic m;
        m = 1'b0;
        unique case (edge_sel_t'(sel))
            edge_rise: m = now_high;
            edge_fall: m = ~now_high;
            edge_both: m = 1'b1;
            edge_rsvd: m = 1'b0;
        endcase
        return m;
    endfunction

    // ---------------------------------------------------------------
    // apb read decode
    // ---------------------------------------------------------------
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        if (paddr == idx_addr(`IDX_POWER_GATE)) begin
            rd_word = {26'h0, r_ff.pgate};
        end else if (paddr == idx_addr(`IDX_CHAN1_CTRL)) begin
            rd_word = {27'h0, r_ff.lvl[0], r_ff.edge_sel[0], r_ff.samp_sel[0]};
        end else if (paddr == idx_addr(`IDX_CHAN2_CTRL)) begin
            rd_word = {27'h0, r_ff.lvl[1], r_ff.edge_sel[1], r_ff.samp_sel[1]};
        end else if (paddr == {16'h0, `ADDR_IRQ_STATUS}) begin
            rd_word = {30'h0, r_ff.status};
        end else if (paddr == {16'h0, `ADDR_IRQ_MASK}) begin
            rd_word = {30'h0, r_ff.mask};
        end else if (paddr == {16'h0, `ADDR_MODE}) begin
            rd_word = {31'h0, r_ff.slow};
        end else begin
            rd_hit = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // low-frequency clock enables
    // ---------------------------------------------------------------
    always_comb begin
        lf_tick = (r_ff.lf_cnt >= LF_DIV - 16'h0001);
        lf4_tick = lf_tick && (r_ff.lf_q == 2'(`LF_PRESCALE - 1));
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        nxt_r = r_ff;
        tick = 2'b00;
        edge_hit = 2'b00;
        w1c = 2'b00;

        // apb slave with one wait state
        acc_wr = psel && penable && r_ff.pready && pwrite;
        acc_rd = psel && penable && !r_ff.pready;
        nxt_r.pready = acc_rd;
        nxt_r.pslverr = acc_rd && !rd_hit;
        if (acc_rd) begin
            nxt_r.prdata = pwrite ? 32'h0000_0000 : rd_word;
        end

        // low-frequency divider
        if (lf_tick) begin
            nxt_r.lf_cnt = 16'h0000;
            nxt_r.lf_q = r_ff.lf_q + 2'h1;
        end else begin
            nxt_r.lf_cnt = r_ff.lf_cnt + 16'h0001;
        end

        // register writes
        if (acc_wr) begin
            if (paddr == idx_addr(`IDX_POWER_GATE)) begin
                nxt_r.pgate = pwdata[`PGATE_WIDTH-1:0];
            end
            if (paddr == idx_addr(`IDX_CHAN1_CTRL) && r_ff.pgate[1]) begin
                nxt_r.samp_sel[0] = pwdata[`CTRL_SAMP_LSB +: 2];
                nxt_r.edge_sel[0] = pwdata[`CTRL_EDGE_LSB +: 2];
            end
            if (paddr == idx_addr(`IDX_CHAN2_CTRL) && r_ff.pgate[2]) begin
                nxt_r.samp_sel[1] = pwdata[`CTRL_SAMP_LSB +: 2];
                nxt_r.edge_sel[1] = pwdata[`CTRL_EDGE_LSB +: 2];
            end
            if (paddr == {16'h0, `ADDR_IRQ_STATUS}) begin
                w1c = pwdata[1:0];
            end
            if (paddr == {16'h0, `ADDR_IRQ_MASK}) begin
                nxt_r.mask = pwdata[1:0];
            end
            if (paddr == {16'h0, `ADDR_MODE}) begin
                nxt_r.slow = pwdata[`MODE_SLOW_BIT];
            end
        end

        // channels 1 and 2
        for (int c = 0; c < 2; c++) begin
            nxt_r.sync1[c] = ext_int_pin[c];
            nxt_r.sync2[c] = r_ff.sync1[c];
            nxt_r.req[c] = 1'b0;
            if (!r_ff.pgate[c+1]) begin
                // gated channel clears its divider count and its sample and edge selects
                nxt_r.div_cnt[c] = 4'h0;
                nxt_r.samp_sel[c] = 2'h0;
                nxt_r.edge_sel[c] = 2'h0;
            end else begin
                if (r_ff.slow) begin
                    tick[c] = lf4_tick;
                    nxt_r.div_cnt[c] = 4'h0;
                end else begin
                    tick[c] = r_ff.div_cnt[c] >= samp_limit(r_ff.samp_sel[c]);
                    nxt_r.div_cnt[c] = tick[c] ? 4'h0 : r_ff.div_cnt[c] + 4'h1;
                end
                if (tick[c]) begin
                    nxt_r.nc_shift[c] = {r_ff.nc_shift[c][1:0], r_ff.sync2[c]};
                    // three agreeing samples move the filtered level
                    if ((&nxt_r.nc_shift[c] || ~|nxt_r.nc_shift[c])
                        && nxt_r.nc_shift[c][0] != r_ff.filt[c]) begin
                        nxt_r.filt[c] = nxt_r.nc_shift[c][0];
                        edge_hit[c] = edge_match(r_ff.edge_sel[c], nxt_r.filt[c]);
                    end
                end
                if (edge_hit[c]) begin
                    nxt_r.req[c] = 1'b1;
                    nxt_r.lvl[c] = nxt_r.filt[c];
                end
            end
            // set wins over software clear and acceptance
            nxt_r.status[c] = (r_ff.status[c] && !w1c[c] && !int_accept[c])
                || r_ff.req[c];
        end

        nxt_r.irq = |(nxt_r.status & nxt_r.mask);
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign prdata = r_ff.prdata;
    assign pready = r_ff.pready;
    assign pslverr = r_ff.pslverr;
    assign chan_req = r_ff.req;
    assign chan_filtered = r_ff.filt;
    assign irq = r_ff.irq;

endmodule

/* File: sim/ext_int_ctrl_checker.sv */
// port assertions for ext_int_ctrl
// assumes binding onto every ext_int_ctrl instance
module ext_int_ctrl_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] ext_int_pin,
    input wire logic [1:0] int_accept,
    input wire logic [1:0] chan_req,
    input wire logic [1:0] chan_filtered,
    input wire logic irq
);
    // ----
    // properties
    // ----
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_wait: assert property (psel && penable && !pready |=> pready) else $error("late");
    a_err_zero: assert property (pslverr |-> pready ##0 prdata == 32'h0) else $error("err");
    a_gate_high: assert property (pready && paddr == 32'h3ddc |-> prdata[31:6] == 26'h0)
        else $error("gate bits");
    a_ctrl_high: assert property (pready && paddr[31:3] == 29'h7ec |-> prdata[31:5] == 27'h0)
        else $error("ctrl bits");
    a_req_single: assert property (chan_req != 2'h0 |=> (chan_req & $past(chan_req)) == 2'h0)
        else $error("long req");
    a_filt_pin: assert property ($changed(chan_filtered[0]) |-> $past(ext_int_pin[0], 3) == chan_filtered[0])
        else $error("unfiltered");
    a_irq_rise: assert property ($rose(irq) |-> ($past(chan_req) | $past(chan_req, 2)) != 2'h0
        || $past(psel) || $past(psel, 2)) else $error("irq cause");
    a_irq_hold: assert property (irq && !psel && !$past(psel) && int_accept == 2'h0
        && $past(int_accept) == 2'h0 |=> irq) else $error("irq drop");
endmodule
bind ext_int_ctrl ext_int_ctrl_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_int_pin(ext_int_pin), .int_accept(int_accept), .chan_req(chan_req),
    .chan_filtered(chan_filtered), .irq(irq));

/* File: sim/ext_int_pins.sv */
// off-chip signals on the two external interrupt pins
// assumes the bench changes level and glitch just after pclk edges
module ext_int_pins (
    input wire logic pclk,
    input wire logic [1:0] level,
    input wire logic [1:0] glitch,
    output logic [1:0] pin
);
    initial pin = 2'h0;
    // a glitch flips the pin while held
    always @(posedge pclk) pin <= level ^ glitch;
endmodule

/* File: sim/ext_int_ctrl_test.sv */
// bench for ext_int_ctrl: apb tasks, pin model, queued read checks
// assumes package, pin model and checker are compiled first
module ext_int_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, d;
    logic pready, pslverr, irq;
    logic [1:0] pin, chan_req, chan_filtered, level = 2'h0, glitch = 2'h0, int_accept = 2'h0;
    logic [33:0] q[$];
    logic [33:0] e;
    logic [31:0] ra[6] = '{32'h3ddc, 32'h3f60, 32'h3f64, 32'h0, 32'h4, 32'h8};
    int failures = 0, n_tests = 0, nreq = 0, n0, seed = 32'hd85c9b64;
    ext_int_ctrl #(.LF_DIV(16'h0004)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_int_pin(pin), .int_accept(int_accept),
        .chan_req(chan_req), .chan_filtered(chan_filtered), .irq(irq));
    ext_int_pins far (.pclk(pclk), .level(level), .glitch(glitch), .pin(pin));
    initial forever #4 pclk = ~pclk;
    initial begin
        #100000;
        failures++;
        test_done;
    end
    // ----
    // tasks
    // ----
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("%0d checks, %0d failures", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] v,
            input logic [32:0] x);
        q.push_back({!w, x});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        apb(1'b1, a, v, 33'h0);
    endtask
    task automatic rd(input logic [31:0] a, input logic [32:0] x);
        apb(1'b0, a, 32'h0, x);
    endtask
    task automatic hit(input int ch, input logic v, input int c);
        int m;
        logic want;
        m = nreq;
        want = (c == 2) || (v && c == 0) || (!v && c == 1);
        level[ch] <= v;
        repeat (30) @(posedge pclk);
        check(32'(nreq - m), 32'(want));
        check(32'(irq), 32'(want));
        if (want) rd(ra[ch + 1], 33'({v, 2'(c), 2'h0}));
        wr(32'h0, 32'h3);
    endtask
    task automatic lat(input int lo, input int hi);
        int m, t;
        m = nreq;
        t = 0;
        level[0] <= ~level[0];
        while (nreq == m && t < 200) begin
            @(posedge pclk);
            t++;
        end
        check(32'(t >= lo && t <= hi), 32'h1);
        repeat (4) @(posedge pclk);
    endtask
    always @(negedge pclk) if (chan_req !== 2'h0) nreq++;
    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            e = q.pop_front();
            check(32'(pslverr), 32'(e[32]));
            if (e[33]) check(prdata, e[31:0]);
        end
    end
    // ----
    // scenarios
    // ----
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ra[i]) rd(ra[i], 33'h0);
        rd(32'h100, {1'b1, 32'h0});
        wr(32'h3f60, 32'hff);
        rd(32'h3f60, 33'h0);
        wr(32'h3ddc, 32'hff);
        rd(32'h3ddc, 33'h3f);
        for (int i = 0; i < 4; i++) begin
            d = $random(seed);
            wr(32'h3f64, d);
            rd(32'h3f64, 33'(d[3:0]));
        end
        $display("registers done");
        for (int ch = 0; ch < 2; ch++) begin
            for (int c = 0; c < 4; c++) begin
                wr(32'h4, 32'h0);
                wr(ra[ch + 1], 32'(c << 2));
                wr(32'h0, 32'h3);
                wr(32'h4, 32'(1 << ch));
                hit(ch, 1'b1, c);
                hit(ch, 1'b0, c);
            end
        end
        for (int s = 0; s < 4; s++) begin
            wr(32'h3f60, 32'(8 + s));
            n0 = (s == 0) ? 1 : 2 << s;
            lat(2 * n0 + 2, 3 * n0 + 6);
        end
        $display("edges done");
        wr(32'h3f60, 32'h8);
        wr(32'h8, 32'h1);
        repeat (48) @(posedge pclk);
        wr(32'h0, 32'h3);
        lat(34, 54);
        wr(32'h8, 32'h0);
        repeat (5) @(posedge pclk);
        wr(32'h0, 32'h3);
        wr(32'h4, 32'h1);
        lat(4, 9);
        repeat (20) @(posedge pclk);
        check(32'(irq), 32'h1);
        int_accept <= 2'h1;
        @(posedge pclk);
        int_accept <= 2'h0;
        repeat (2) @(posedge pclk);
        check(32'(irq), 32'h0);
        wr(32'h4, 32'h0);
        lat(4, 9);
        rd(32'h0, 33'h1);
        wr(32'h4, 32'h1);
        repeat (2) @(posedge pclk);
        check(32'(irq), 32'h1);
        wr(32'h0, 32'h1);
        repeat (2) @(posedge pclk);
        check(32'(irq), 32'h0);
        $display("interrupt done");
        n0 = nreq;
        glitch[0] <= 1'b1;
        @(posedge pclk);
        glitch[0] <= 1'b0;
        repeat (20) @(posedge pclk);
        check(32'(nreq - n0), 32'h0);
        lat(4, 9);
        wr(32'h4, 32'h0);
        wr(32'h3ddc, 32'h39);
        n0 = nreq;
        level <= ~level;
        repeat (60) @(posedge pclk);
        check(32'(nreq - n0), 32'h0);
        rd(32'h3f60, 33'h0);
        $display("gating done");
        test_done;
    end
endmodule
